// File: rtl/sfq_flash_cmd.sv
// Read and program command sequencer of a multi-line serial flash.
// Assumes sclk, cs_b and dq_in are asynchronous pins; mode inputs are
// static and on the system clock.
`default_nettype none
// Operation
// - Single-edge read opcode set decoded
// - Double-edge fast reads only, no plain read
// - Four-byte opcodes always take four address bytes
// - Extended takes every opcode; dual and quad refuse plain read and the other width
// - Fast reads insert dummy clocks before data
// - Extended quad I/O: opcode serial, address quad
// - Dual opcode two lines, quad four lines
// - Double-edge address captured on both edges
// - Opcode, single-edge address, program data bytes on rising edges
// - Program starts at chip select rise
// - Unaligned data wraps within page
// - Excess bytes keep only last page
// - Short program leaves other bytes unchanged
// - Ready flag low while programming
// - Write latch cleared after every program
// - Timeout clears latch, sets program fail
// - Off-boundary end: no program, no flags
// - Locked sector: no program, flags 1, 4
// - Program variants by protocol and width
// - Read address increments per output byte
// - Opcode 06h sets latch; 04h clears it only while protect flag is clear
module sfq_flash_cmd
  import sfq_pkg::*;
#(
  parameter int PAGE_LOG = 8,
  parameter int MEM_LOG = 9,
  parameter int SECT_LOG = 16,
  parameter int NSECT_LOG = 10,
  parameter int PROG_CYCLES = PROG_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq_out,
  output logic [3:0] dq_oe,
  input wire logic [1:0] protocol,
  input wire logic double_rate,
  input wire logic addr4_mode,
  input wire logic [3:0] dummy_cycles,
  input wire logic [2**NSECT_LOG-1:0] sector_lock,
  input wire logic program_fault,
  input wire logic clear_flags,
  output logic wel,
  output logic [7:0] fsr
);
  localparam int PAGE = 2**PAGE_LOG;
  localparam int MEM = 2**MEM_LOG;

  typedef struct packed {
    logic sck1, sck2, sckd, cs1, cs2, csd;
    logic [3:0] dq1, dq2;
    sfq_state_t st;
    logic [31:0] sh;
    logic [5:0] cnt;
    logic [7:0] op;
    sfq_dec_t dc;
    logic [31:0] addr;
    logic [7:0] ob;
    logic [3:0] orem;
    logic nb;
    logic [PAGE-1:0][7:0] pb;
    logic [PAGE-1:0] pv;
    logic [MEM-1:0][7:0] mem;
    logic wel;
    logic [7:0] fsr;
    logic [31:0] bc;
    logic [3:0] dqo, oe;
  } sfq_regs_t;

  sfq_regs_t s_reg, s_next;
  logic rs1_b, rst_sync_b;
  logic sck_rise, sck_fall, cs_rise, cs_fall, oev, cap, lock_hit;
  logic prog_go, busy_end;
  logic [2:0] lw;
  logic [5:0] abits;

  // ----------------------------------------------------------------
  // Link edges and phase widths
  // ----------------------------------------------------------------
  assign lw = (protocol == PR_QUAD) ? 3'h4 :
              (protocol == PR_DUAL) ? 3'h2 : 3'h1;
  assign sck_rise = s_reg.sck2 & ~s_reg.sckd;
  assign sck_fall = ~s_reg.sck2 & s_reg.sckd;
  assign cs_rise = s_reg.cs2 & ~s_reg.csd;
  assign cs_fall = ~s_reg.cs2 & s_reg.csd;
  assign cap = double_rate ? (sck_rise | sck_fall) : sck_rise;
  assign oev = double_rate ? (sck_rise | sck_fall) : sck_fall;
  assign abits = (s_reg.dc.a4 | addr4_mode) ? ADDR4_BITS : ADDR3_BITS;
  assign lock_hit = sector_lock[s_reg.addr[SECT_LOG +: NSECT_LOG]];
  // Only whole bytes, with the latch set, may start a program
  assign prog_go = cs_rise && s_reg.st == S_PDAT && s_reg.wel &&
                   s_reg.nb && s_reg.cnt == 6'h0;
  assign busy_end = s_reg.st == S_BUSY && s_reg.bc == 32'h1;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] nsh;
    logic [7:0] b;
    logic [PAGE_LOG-1:0] pi;
    nsh = '0;
    b = '0;
    pi = '0;
    s_next = s_reg;
    s_next.sck1 = sclk;
    s_next.sck2 = s_reg.sck1;
    s_next.sckd = s_reg.sck2;
    s_next.cs1 = cs_b;
    s_next.cs2 = s_reg.cs1;
    s_next.csd = s_reg.cs2;
    s_next.dq1 = dq_in;
    s_next.dq2 = s_reg.dq1;
    // Clear first, so a same-cycle set below wins
    if (clear_flags) begin
      s_next.fsr[FSR_PERR] = 1'b0;
      s_next.fsr[FSR_PROT] = 1'b0;
    end
    unique case (s_reg.st)
      S_IDLE: if (cs_fall) begin
        s_next.st = S_CMD;
        s_next.cnt = '0;
      end
      S_CMD: if (sck_rise) begin
        nsh = shin(s_reg.sh, s_reg.dq2, lw);
        s_next.sh = nsh;
        s_next.cnt = s_reg.cnt + {3'h0, lw};
        if (s_reg.cnt + {3'h0, lw} == CMD_BITS) begin
          s_next.op = nsh[7:0];
          s_next.cnt = '0;
          s_next.dc = decode(nsh[7:0], protocol, lw, double_rate);
          if (nsh[7:0] == OP_WREN || nsh[7:0] == OP_WRDI)
            s_next.st = S_CMDX;
          else if (s_next.dc.ok)
            s_next.st = S_ADDR;
          else
            s_next.st = S_IGN;
        end
      end
      // A clock beyond the eighth bit voids the command
      S_CMDX: if (sck_rise) s_next.st = S_IGN;
      S_ADDR: if (cap) begin
        nsh = shin(s_reg.sh, s_reg.dq2, s_reg.dc.aw);
        s_next.sh = nsh;
        s_next.cnt = s_reg.cnt + {3'h0, s_reg.dc.aw};
        if (s_reg.cnt + {3'h0, s_reg.dc.aw} == abits) begin
          s_next.addr = (abits == ADDR4_BITS) ? nsh : {8'h0, nsh[23:0]};
          s_next.cnt = '0;
          if (s_reg.dc.prog) begin
            s_next.st = S_PDAT;
            s_next.pv = '0;
            s_next.nb = 1'b0;
          end else if (s_reg.dc.fast && dummy_cycles != 4'h0) begin
            s_next.st = S_DUM;
          end else begin
            s_next.st = S_RDAT;
            s_next.orem = '0;
          end
        end
      end
      S_DUM: if (sck_rise) begin
        s_next.cnt = s_reg.cnt + 6'h1;
        if (s_reg.cnt + 6'h1 == {2'h0, dummy_cycles}) begin
          s_next.st = S_RDAT;
          s_next.orem = '0;
        end
      end
      S_RDAT: if (oev) begin
        if (s_reg.orem == 4'h0) begin
          b = s_reg.mem[s_reg.addr[MEM_LOG-1:0]];
          s_next.addr = s_reg.addr + 32'h1;
          s_next.orem = 4'h8 - {1'b0, s_reg.dc.dw};
        end else begin
          b = s_reg.ob;
          s_next.orem = s_reg.orem - {1'b0, s_reg.dc.dw};
        end
        // Single-line data leaves on line one
        s_next.ob = b << s_reg.dc.dw;
        s_next.dqo = (s_reg.dc.dw == 3'h1) ? {2'h0, b[7], 1'b0} :
                     (s_reg.dc.dw == 3'h2) ? {2'h0, b[7:6]} : b[7:4];
        s_next.oe = (s_reg.dc.dw == 3'h1) ? 4'h2 :
                    (s_reg.dc.dw == 3'h2) ? 4'h3 : 4'hf;
      end
      S_PDAT: if (sck_rise) begin
        nsh = shin(s_reg.sh, s_reg.dq2, s_reg.dc.dw);
        s_next.sh = nsh;
        s_next.cnt = s_reg.cnt + {3'h0, s_reg.dc.dw};
        if (s_reg.cnt + {3'h0, s_reg.dc.dw} == CMD_BITS) begin
          // Offset wraps in page; later bytes overwrite earlier ones
          s_next.pb[s_reg.addr[PAGE_LOG-1:0]] = nsh[7:0];
          s_next.pv[s_reg.addr[PAGE_LOG-1:0]] = 1'b1;
          s_next.addr[PAGE_LOG-1:0] = s_reg.addr[PAGE_LOG-1:0] + 1'b1;
          s_next.nb = 1'b1;
          s_next.cnt = '0;
        end
      end
      S_BUSY: begin
        s_next.bc = s_reg.bc - 32'h1;
        if (busy_end) begin
          if (program_fault) begin
            s_next.fsr[FSR_PERR] = 1'b1;
          end else begin
            for (int i = 0; i < PAGE; i++) begin
              pi = PAGE_LOG'(i);
              // Untouched bytes keep their contents
              if (s_reg.pv[i])
                s_next.mem[{s_reg.addr[MEM_LOG-1:PAGE_LOG], pi}] =
                  s_reg.mem[{s_reg.addr[MEM_LOG-1:PAGE_LOG], pi}] &
                  s_reg.pb[i];
            end
          end
          s_next.wel = 1'b0;
          s_next.fsr[FSR_RDY] = 1'b1;
          s_next.st = s_reg.cs2 ? S_IDLE : S_IGN;
        end
      end
      S_IGN: ;
    endcase
    // Chip select rise ends any transfer; a busy array ignores the link
    if (cs_rise && s_reg.st != S_BUSY) begin
      s_next.st = S_IDLE;
      s_next.oe = 4'h0;
      if (s_reg.st == S_CMDX) begin
        if (s_reg.op == OP_WREN)
          s_next.wel = 1'b1;
        else if (!s_reg.fsr[FSR_PROT])
          s_next.wel = 1'b0;
      end
      if (prog_go) begin
        if (lock_hit) begin
          s_next.fsr[FSR_PROT] = 1'b1;
          s_next.fsr[FSR_PERR] = 1'b1;
        end else begin
          s_next.st = S_BUSY;
          s_next.bc = PROG_CYCLES;
          s_next.fsr[FSR_RDY] = 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rs1_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rs1_b <= 1'b1;
      rst_sync_b <= rs1_b;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s_reg <= '0;
      s_reg.mem <= '1;
      s_reg.fsr <= FSR_RST;
      s_reg.st <= S_IDLE;
      s_reg.cs1 <= 1'b1;
      s_reg.cs2 <= 1'b1;
      s_reg.csd <= 1'b1;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign dq_out = s_reg.dqo;
  assign dq_oe = s_reg.oe;
  assign wel = s_reg.wel;
  assign fsr = s_reg.fsr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking dcb @(posedge clock); endclocking
  default disable iff (!rst_sync_b);

  AST_BUSY_NOT_READY: assert property (
    s_reg.st == S_BUSY |-> !fsr[FSR_RDY]) else $error("ready while busy");
  AST_END_CLEARS_WEL: assert property (
    clk_en && busy_end |=> !wel && fsr[FSR_RDY])
    else $error("latch or ready wrong after program");
  AST_FAULT_FLAG: assert property (
    clk_en && busy_end && program_fault |=> fsr[FSR_PERR] && !wel)
    else $error("timeout did not flag");
  AST_LOCKED: assert property (
    clk_en && prog_go && lock_hit |=>
      wel && fsr[FSR_PROT] && fsr[FSR_PERR] && s_reg.st == S_IDLE)
    else $error("locked program handled wrong");
  AST_NO_LATCH: assert property (
    clk_en && cs_rise && s_reg.st == S_PDAT && !wel && !clear_flags
      |=> s_reg.st == S_IDLE && $stable(fsr)) else $error("program ran");
  AST_PARTIAL_BYTE: assert property (
    clk_en && cs_rise && s_reg.st == S_PDAT && s_reg.cnt != 6'h0 &&
    !clear_flags |=> s_reg.st == S_IDLE && $stable(wel) && $stable(fsr))
    else $error("partial byte not ignored");
  AST_WREN_SETS: assert property (
    clk_en && cs_rise && s_reg.st == S_CMDX && s_reg.op == OP_WREN
      |=> wel) else $error("latch not set");
  AST_QUAD_CMD: assert property (
    clk_en && s_reg.st == S_CMD && sck_rise && protocol == PR_QUAD &&
    s_reg.cnt == 6'h0 |=> s_reg.cnt == 6'h4)
    else $error("quad opcode not four lines");
  AST_PROG_START: assert property (
    clk_en && prog_go && !lock_hit |=>
      s_reg.st == S_BUSY && s_reg.bc == PROG_CYCLES)
    else $error("program did not start");
  AST_READ_INC: assert property (
    clk_en && s_reg.st == S_RDAT && oev && s_reg.orem == 4'h0 &&
    !cs_rise |=> s_reg.addr == $past(s_reg.addr) + 32'h1)
    else $error("read address not advanced");

  COV_PROG_DONE: cover property (clk_en && busy_end && !program_fault);
  COV_READ_END: cover property (cs_rise && s_reg.st == S_RDAT);
  COV_LOCKED: cover property (clk_en && prog_go && lock_hit);
  COV_QUAD_READ: cover property (s_reg.st == S_RDAT && dq_oe == 4'hf);
endmodule
`default_nettype wire

// File: rtl/sfq_pkg.sv
// Constants, types and opcode decoding for the serial flash sequencer.
// Assumes a 20 MHz system clock that samples every link pin.
`default_nettype none
package sfq_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int PROG_NS = 500000;
  // Least time, rounded up to whole cycles
  localparam int PROG_CYC = (PROG_NS + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_RD3 = 8'h03, OP_RD4 = 8'h13;
  localparam logic [7:0] OP_FR3 = 8'h0b, OP_FR4 = 8'h0c, OP_FRD = 8'h0d;
  localparam logic [7:0] OP_DO3 = 8'h3b, OP_DO4 = 8'h3c, OP_DOD = 8'h3d;
  localparam logic [7:0] OP_DI3 = 8'hbb, OP_DI4 = 8'hbc, OP_DID = 8'hbd;
  localparam logic [7:0] OP_QO3 = 8'h6b, OP_QO4 = 8'h6c, OP_QOD = 8'h6d;
  localparam logic [7:0] OP_QI3 = 8'heb, OP_QI4 = 8'hec, OP_QID = 8'hed;
  localparam logic [7:0] OP_WREN = 8'h06, OP_WRDI = 8'h04;
  localparam logic [7:0] OP_PP = 8'h02, OP_DIP = 8'ha2, OP_EDP = 8'hd2;
  localparam logic [7:0] OP_QIP = 8'h32, OP_EQP = 8'h38;
  // ----------------------------------------------------------------
  // Flag status layout, protocols, reset values
  // ----------------------------------------------------------------
  localparam int FSR_RDY = 7, FSR_PERR = 4, FSR_PROT = 1;
  localparam logic [7:0] FSR_RST = 8'h80;
  localparam logic [1:0] PR_EXT = 2'h0, PR_DUAL = 2'h1, PR_QUAD = 2'h2;
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR3_BITS = 6'h18, ADDR4_BITS = 6'h20;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001, S_CMD = 9'h002, S_CMDX = 9'h004, S_ADDR = 9'h008,
    S_DUM = 9'h010, S_RDAT = 9'h020, S_PDAT = 9'h040, S_BUSY = 9'h080,
    S_IGN = 9'h100
  } sfq_state_t;

  typedef struct packed {
    logic ok;
    logic prog;
    logic a4;
    logic fast;
    logic [2:0] aw;
    logic [2:0] dw;
  } sfq_dec_t;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic sfq_dec_t decode(input logic [7:0] op,
                                      input logic [1:0] pr,
                                      input logic [2:0] w,
                                      input logic dtr);
    sfq_dec_t d;
    d = '0;
    d.aw = w;
    d.dw = w;
    d.fast = 1'b1;
    d.a4 = op inside {OP_RD4, OP_FR4, OP_DO4, OP_DI4, OP_QO4, OP_QI4};
    case (op)
      OP_RD3, OP_RD4: begin
        d.ok = (pr == PR_EXT) && !dtr;
        d.fast = 1'b0;
      end
      OP_FR3, OP_FR4, OP_FRD: d.ok = dtr == (op == OP_FRD);
      OP_DO3, OP_DO4, OP_DOD: begin
        d.ok = (pr != PR_QUAD) && (dtr == (op == OP_DOD));
        d.dw = 3'h2;
      end
      OP_DI3, OP_DI4, OP_DID: begin
        d.ok = (pr != PR_QUAD) && (dtr == (op == OP_DID));
        d.aw = 3'h2;
        d.dw = 3'h2;
      end
      OP_QO3, OP_QO4, OP_QOD: begin
        d.ok = (pr != PR_DUAL) && (dtr == (op == OP_QOD));
        d.dw = 3'h4;
      end
      OP_QI3, OP_QI4, OP_QID: begin
        d.ok = (pr != PR_DUAL) && (dtr == (op == OP_QID));
        d.aw = 3'h4;
        d.dw = 3'h4;
      end
      OP_PP: d.ok = !dtr;
      OP_DIP, OP_EDP: begin
        d.ok = !dtr && (pr != PR_QUAD);
        d.aw = (op == OP_EDP) ? 3'h2 : w;
        d.dw = 3'h2;
      end
      OP_QIP, OP_EQP: begin
        d.ok = !dtr && (pr != PR_DUAL);
        d.aw = (op == OP_EQP) ? 3'h4 : w;
        d.dw = 3'h4;
      end
      default: d.ok = 1'b0;
    endcase
    d.prog = op inside {OP_PP, OP_DIP, OP_EDP, OP_QIP, OP_EQP};
    // Non-extended protocols run every phase on all their lines
    if (pr != PR_EXT) begin
      d.aw = w;
      d.dw = w;
    end
    return d;
  endfunction

  function automatic logic [31:0] shin(input logic [31:0] v,
                                       input logic [3:0] d,
                                       input logic [2:0] w);
    case (w)
      3'h1: shin = {v[30:0], d[0]};
      3'h2: shin = {v[29:0], d[1:0]};
      default: shin = {v[27:0], d};
    endcase
  endfunction
endpackage
`default_nettype wire

// File: tb/sfq_host_model.sv
// Host side of the serial link: drives chip select, link clock, data lines.
// Assumes the bench's system clock; every change lands 1 ns after its edge.
`default_nettype none
module sfq_host_model (
  input wire logic clock,
  output logic sclk,
  output logic cs_b,
  output logic [3:0] dq_in,
  input wire logic [3:0] dq_out,
  input wire logic [3:0] dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Link primitives
  // ------------------------------------------------------------
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    dq_in = 4'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // 400 ns link period; unused lines toggle so stale values never match
  task automatic cyc(input logic [31:0] v, input int n, input int wi,
                     input int wo, output logic [31:0] r);
    logic [3:0] ln;
    r = '0;
    for (int i = 0; i < n; i++) begin
      case (wi)
        1: dq_in = {~dq_in[3:1], v[31]};
        2: dq_in = {~dq_in[3:2], v[31:30]};
        4: dq_in = v[31:28];
        default: dq_in = ~dq_in;
      endcase
      v = v << wi;
      tick(4);
      sclk = 1'b1;
      tick(4);
      // Released lines float high on their pull-ups
      ln = dq_out | ~dq_oe;
      case (wo)
        1: r = {r[30:0], ln[1]};
        2: r = {r[29:0], ln[1:0]};
        4: r = {r[27:0], ln};
        default: r = r;
      endcase
      sclk = 1'b0;
    end
  endtask

  // Select is raised only after the last whole unit has been clocked
  task automatic xfer(input logic [7:0] op, input int wc,
                      input logic [31:0] adr, input int ab, input int wa,
                      input int dm, input logic [31:0] dat, input int db,
                      input int wd, input bit rd, output logic [31:0] r);
    tick(1);
    cs_b = 1'b0;
    tick(4);
    cyc({op, 24'h0}, 8 / wc, wc, 0, r);
    if (ab > 0) begin
      cyc(adr << (32 - ab), ab / wa, wa, 0, r);
    end
    cyc(32'h0, dm, 0, 0, r);
    if (db > 0) begin
      cyc(rd ? 32'h0 : dat << (32 - db), db / wd, rd ? 0 : wd,
          rd ? wd : 0, r);
    end
    tick(4);
    cs_b = 1'b1;
    dq_in = ~dq_in;
    tick(8);
  endtask
endmodule
`default_nettype wire

// File: tb/sfq_flash_cmd_tb_top.sv
// Self-checking bench of the flash command sequencer.
// Assumes a 20 MHz clock, a 20-cycle program time and the host model.
`default_nettype none
module sfq_flash_cmd_tb_top
  import sfq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0] op;
    logic [1:0] pr;
    int wc, wa, wd, ab, dm;
  } sfq_rd_row_t;
  logic clock = 1'b0;
  logic rst_b, sclk, cs_b, program_fault, clear_flags, wel, clk_en;
  logic double_rate, addr4_mode;
  logic [3:0] dq_in, dq_out, dq_oe, dummy_cycles;
  logic [1:0] protocol;
  logic [1023:0] sector_lock;
  logic [7:0] fsr;
  logic [31:0] r;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  sfq_rd_row_t rows [18] = '{
    '{8'h03, PR_EXT, 1, 1, 1, 24, 0}, '{8'h13, PR_EXT, 1, 1, 1, 32, 0},
    '{8'h0b, PR_EXT, 1, 1, 1, 24, 8}, '{8'h0c, PR_EXT, 1, 1, 1, 32, 8},
    '{8'h3b, PR_EXT, 1, 1, 2, 24, 8}, '{8'h3c, PR_EXT, 1, 1, 2, 32, 8},
    '{8'hbb, PR_EXT, 1, 2, 2, 24, 8}, '{8'hbc, PR_EXT, 1, 2, 2, 32, 8},
    '{8'h6b, PR_EXT, 1, 1, 4, 24, 8}, '{8'h6c, PR_EXT, 1, 1, 4, 32, 8},
    '{8'heb, PR_EXT, 1, 4, 4, 24, 8}, '{8'hec, PR_EXT, 1, 4, 4, 32, 8},
    '{8'h0b, PR_DUAL, 2, 2, 2, 24, 8}, '{8'h3b, PR_DUAL, 2, 2, 2, 24, 8},
    '{8'hbb, PR_DUAL, 2, 2, 2, 24, 8}, '{8'h0b, PR_QUAD, 4, 4, 4, 24, 8},
    '{8'h6b, PR_QUAD, 4, 4, 4, 24, 8}, '{8'heb, PR_QUAD, 4, 4, 4, 24, 8}};

  always #25 clock = ~clock;

  sfq_flash_cmd #(.PROG_CYCLES(20)) dut (
    .clock(clock), .rst_b(rst_b), .clk_en(clk_en), .sclk(sclk),
    .cs_b(cs_b), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .protocol(protocol), .double_rate(double_rate),
    .addr4_mode(addr4_mode),
    .dummy_cycles(dummy_cycles), .sector_lock(sector_lock),
    .program_fault(program_fault), .clear_flags(clear_flags),
    .wel(wel), .fsr(fsr));

  sfq_host_model host (
    .clock(clock), .sclk(sclk), .cs_b(cs_b), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe));
  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (bad_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Whole run is near 14k cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic cmd(input logic [7:0] op);
    host.xfer(op, 1, 32'h0, 0, 1, 0, 32'h0, 0, 1, 1'b0, r);
  endtask

  task automatic prog(input logic [31:0] a, input logic [31:0] d,
                      input int n);
    host.xfer(OP_PP, 1, a, 24, 1, 0, d, n, 1, 1'b0, r);
  endtask

  task automatic rd8(input logic [31:0] a, input logic [7:0] exp);
    host.xfer(OP_RD3, 1, a, 24, 1, 0, 32'h0, 8, 1, 1'b1, r);
    chk(r, {24'h0, exp});
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    while (fsr[7] !== 1'b1 && k < 200) begin
      host.tick(1);
      k++;
    end
    chk({31'h0, k < 200}, 32'h1);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_wel();
    chk({16'h0, fsr, 3'h0, wel, dq_oe}, {24'h80, 8'h00});
    cmd(OP_WREN);
    chk({31'h0, wel}, 32'h1);
    cmd(OP_WRDI);
    chk({31'h0, wel}, 32'h0);
  endtask

  // Unaligned start: third byte must wrap to the page start
  task automatic t_prog();
    cmd(OP_WREN);
    prog(32'h0000fe, 32'h00a55a3c, 24);
    chk({31'h0, fsr[7]}, 32'h0);
    wait_ready();
    chk({16'h0, fsr, 7'h0, wel}, {24'h80, 8'h00});
    rd8(32'h000000, 8'h3c);
  endtask

  task automatic t_reads();
    foreach (rows[i]) begin
      protocol = rows[i].pr;
      host.xfer(rows[i].op, rows[i].wc, 32'h0000fe, rows[i].ab,
                rows[i].wa, rows[i].dm, 32'h0, 24, rows[i].wd, 1'b1, r);
      chk(r, 32'h00a55aff);
    end
    protocol = PR_EXT;
  endtask

  task automatic t_refuse();
    prog(32'h10, 32'h0, 8);
    chk({24'h0, fsr}, 32'h80);
    cmd(OP_WREN);
    prog(32'h10, 32'h0, 12);
    chk({16'h0, fsr, 7'h0, wel}, {24'h80, 8'h01});
    sector_lock[1] = 1'b1;
    prog(32'h010000, 32'h0, 8);
    chk({16'h0, fsr, 7'h0, wel}, {24'h92, 8'h01});
    sector_lock = '0;
    clear_flags = 1'b1;
    host.tick(2);
    clear_flags = 1'b0;
    host.tick(2);
    chk({24'h0, fsr}, 32'h80);
    program_fault = 1'b1;
    prog(32'h20, 32'h0, 8);
    wait_ready();
    program_fault = 1'b0;
    chk({16'h0, fsr, 7'h0, wel}, {24'h90, 8'h00});
    rd8(32'h10, 8'hff);
    rd8(32'h0, 8'h3c);
  endtask

  // Refused reads leave the lines released, so they read all ones
  task automatic t_modes();
    protocol = PR_QUAD;
    host.xfer(OP_RD3, 4, 32'hfe, 24, 4, 0, 32'h0, 24, 4, 1'b1, r);
    chk(r, 32'h00ffffff);
    protocol = PR_EXT;
    double_rate = 1'b1;
    host.xfer(OP_RD3, 1, 32'hfe, 24, 1, 0, 32'h0, 24, 1, 1'b1, r);
    chk(r, 32'h00ffffff);
    double_rate = 1'b0;
    host.xfer(OP_FRD, 1, 32'hfe, 24, 1, 8, 32'h0, 24, 1, 1'b1, r);
    chk(r, 32'h00ffffff);
    addr4_mode = 1'b1;
    host.xfer(OP_FR3, 1, 32'hfe, 32, 1, 8, 32'h0, 24, 1, 1'b1, r);
    chk(r, 32'h00a55aff);
    addr4_mode = 1'b0;
    dummy_cycles = 4'h4;
    host.xfer(OP_FR3, 1, 32'hfe, 24, 1, 4, 32'h0, 24, 1, 1'b1, r);
    chk(r, 32'h00a55aff);
    dummy_cycles = 4'h0;
    host.xfer(OP_FR3, 1, 32'hfe, 24, 1, 0, 32'h0, 24, 1, 1'b1, r);
    chk(r, 32'h00a55aff);
    dummy_cycles = 4'h8;
    cmd(OP_WREN);
    host.xfer(OP_QIP, 1, 32'h40, 24, 1, 0, 32'h5a, 8, 4, 1'b0, r);
    // A frozen clock must hold the program timer
    clk_en = 1'b0;
    host.tick(40);
    chk({31'h0, fsr[7]}, 32'h0);
    clk_en = 1'b1;
    wait_ready();
    rd8(32'h40, 8'h5a);
    protocol = PR_DUAL;
    host.xfer(OP_WREN, 2, 32'h0, 0, 2, 0, 32'h0, 0, 2, 1'b0, r);
    host.xfer(OP_EDP, 2, 32'h41, 24, 2, 0, 32'hc3, 8, 2, 1'b0, r);
    protocol = PR_EXT;
    wait_ready();
    rd8(32'h41, 8'hc3);
  endtask

  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    double_rate = 1'b0;
    addr4_mode = 1'b0;
    protocol = PR_EXT;
    dummy_cycles = 4'h8;
    sector_lock = '0;
    program_fault = 1'b0;
    clear_flags = 1'b0;
    repeat (6) @(posedge clock);
    #1;
    rst_b = 1'b1;
    host.tick(8);
    t_wel();
    t_prog();
    t_reads();
    t_refuse();
    t_modes();
    wrap_up();
  end
endmodule
`default_nettype wire
